// File: design/oscsf_pkg.sv
// Package for the oscillator select and failover block.
// Assumes a single 50 MHz system clock and an AHB-Lite register bus.
package oscsf_pkg;
	localparam logic [11:0] OSCSF_CTRL_OFFSET = 12'h000;
	localparam logic [11:0] OSCSF_STATUS_OFFSET = 12'h004;
	localparam logic [7:0] OSCSF_CTRL_RESET = 8'hA0;
	localparam logic [7:0] OSCSF_KEY_FIRST = 8'hE7;
	localparam logic [7:0] OSCSF_KEY_SECOND = 8'h18;
	localparam int OSCSF_BIT_INT_EN = 7;
	localparam int OSCSF_BIT_XTL_EN = 6;
	localparam int OSCSF_BIT_WDO_EN = 5;
	localparam int OSCSF_BIT_PRI_FEN = 4;
	localparam int OSCSF_BIT_WDO_FEN = 3;
	localparam int OSCSF_SEL_MSB = 2;
	localparam int OSCSF_CLK_HZ = 50000000;
	localparam int OSCSF_PRI_FAIL_HZ = 1000;
	localparam int OSCSF_PRI_FAIL_CYCLES = OSCSF_CLK_HZ / OSCSF_PRI_FAIL_HZ;
	localparam int OSCSF_WDO_FAIL_CYCLES = 8004;
	localparam logic [1:0] OSCSF_HTRANS_NONSEQ = 2'h2;

	typedef enum logic [2:0] {
		OSCSF_SRC_IPO_FAST = 3'b000,
		OSCSF_SRC_IPO_SLOW = 3'b001,
		OSCSF_SRC_CRYSTAL = 3'b010,
		OSCSF_SRC_WDO = 3'b011,
		OSCSF_SRC_EXT_PIN = 3'b100
	} oscsf_src_t;

	typedef enum logic [1:0] {
		OSCSF_LOCKED = 2'b00,
		OSCSF_KEY1_SEEN = 2'b01,
		OSCSF_UNLOCKED = 2'b10
	} oscsf_lock_t;

	typedef struct packed {
		logic int_en;
		logic xtl_en;
		logic wdo_en;
		logic pri_fen;
		logic wdo_fen;
		logic [2:0] sel;
	} oscsf_ctrl_t;

	typedef struct packed {
		logic [2:0] active_src;
		logic failover;
		logic pri_failed;
		logic wdo_failed;
		logic [1:0] lock_state;
	} oscsf_status_t;
endpackage

// File: design/oscsf_top.sv
// Oscillator source select with unlock key and clock failure supervision.
// Assumes oscillator clocks arrive as asynchronous levels; mux itself is analog.
// Behaviour
// - Control register unlocks only after key E7 then 18 is written.
// - Write after unlock updates register and relocks immediately.
// - Any other write sequence leaves the control register unchanged.
// - Keys must be ordered but may be separated by reads or accesses to other registers.
// - Accesses to other registers do not disturb the unlock state.
// - Failure detection may operate any time after a select write.
// - Internal oscillator enabled at reset; only software clears it.
// - Primary failure raises a nonmaskable event to the CPU.
// - Primary failure with watchdog oscillator enabled fails over to it.
// - No failover when watchdog oscillator selected or disabled.
// - Primary failure declared when clock falls below about 1 kHz.
// - Watchdog oscillator failure raises event without changing source.
// - After watchdog oscillator failure, primary detection stops working.
// - Watchdog failure declared after 8004 cycles without its edge.
// - Internal oscillator selectable at 20MHz or 119kHz.
// - With all sources and detection off, only power-on reset recovers.
// - Select codes 000 to 100 defined; 101 to 111 reserved.
// - Reset value has internal and watchdog oscillator enables set.
module oscsf_top
	import oscsf_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic primary_clk_in,
	input wire logic wdo_clk_in,
	output logic [2:0] clock_source_select,
	output logic clk_switch_hold,
	output logic internal_osc_enable,
	output logic crystal_osc_enable,
	output logic watchdog_osc_enable,
	output logic clock_fail_nmi
);
	logic wr_pend_reg;
	logic rd_pend_reg;
	logic [11:0] addr_reg;
	oscsf_ctrl_t ctrl_reg;
	oscsf_lock_t lock_reg;
	logic [2:0] active_src_reg;
	logic failover_reg;
	logic pri_failed_reg;
	logic wdo_failed_reg;
	logic hold_reg;
	logic [2:0] pri_sync_reg;
	logic [2:0] wdo_sync_reg;
	logic pri_level_reg;
	logic wdo_level_reg;
	logic [15:0] pri_cnt_reg;
	logic [13:0] wdo_cnt_reg;
	logic nmi_reg;
	logic [31:0] hrdata_reg;
	logic [7:0] wbyte;
	logic ctrl_wr;
	logic ctrl_commit;
	oscsf_ctrl_t ctrl_wdata;
	logic failover_now;
	logic pri_edge;
	logic wdo_edge;
	logic pri_fail_now;
	logic wdo_fail_now;
	oscsf_status_t status;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_reg;
	assign wbyte = hwdata[7:0];
	assign ctrl_wr = wr_pend_reg && (addr_reg == OSCSF_CTRL_OFFSET);
	assign ctrl_commit = ctrl_wr && (lock_reg == OSCSF_UNLOCKED);

	// Written value; reserved select codes keep the old source
	always_comb begin
		ctrl_wdata = wbyte;
		if (wbyte[OSCSF_SEL_MSB:0] > OSCSF_SRC_EXT_PIN) begin
			ctrl_wdata.sel = ctrl_reg.sel;
		end
	end

	// Address phase capture
	always_ff @(posedge clk) begin
		if (rst) begin
			wr_pend_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			addr_reg <= 12'h000;
		end else if (hready) begin
			wr_pend_reg <= hsel && (htrans == OSCSF_HTRANS_NONSEQ) && hwrite;
			rd_pend_reg <= hsel && (htrans == OSCSF_HTRANS_NONSEQ) && !hwrite;
			addr_reg <= haddr[11:0];
		end
	end

	// Unlock sequencer; other offsets never touch it
	always_ff @(posedge clk) begin
		if (rst) begin
			lock_reg <= OSCSF_LOCKED;
		end else if (ctrl_wr) begin
			case (lock_reg)
				OSCSF_LOCKED: begin
					lock_reg <= (wbyte == OSCSF_KEY_FIRST) ? OSCSF_KEY1_SEEN : OSCSF_LOCKED;
				end
				OSCSF_KEY1_SEEN: begin
					if (wbyte == OSCSF_KEY_SECOND) begin
						lock_reg <= OSCSF_UNLOCKED;
					end else if (wbyte == OSCSF_KEY_FIRST) begin
						lock_reg <= OSCSF_KEY1_SEEN;
					end else begin
						lock_reg <= OSCSF_LOCKED;
					end
				end
				OSCSF_UNLOCKED: begin
					lock_reg <= OSCSF_LOCKED;
				end
				default: begin
					lock_reg <= OSCSF_LOCKED;
				end
			endcase
		end
	end

	// Control register
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_reg <= OSCSF_CTRL_RESET;
		end else if (ctrl_commit) begin
			ctrl_reg <= ctrl_wdata;
		end
	end

	// Input synchronisers
	always_ff @(posedge clk) begin
		if (rst) begin
			pri_sync_reg <= 3'h0;
			wdo_sync_reg <= 3'h0;
		end else begin
			pri_sync_reg <= {pri_sync_reg[1:0], primary_clk_in};
			wdo_sync_reg <= {wdo_sync_reg[1:0], wdo_clk_in};
		end
	end

	// Settled levels; a change counts once the second and third stages agree
	always_ff @(posedge clk) begin
		if (rst) begin
			pri_level_reg <= 1'b0;
		end else if (pri_sync_reg[1] == pri_sync_reg[2]) begin
			pri_level_reg <= pri_sync_reg[2];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wdo_level_reg <= 1'b0;
		end else if (wdo_sync_reg[1] == wdo_sync_reg[2]) begin
			wdo_level_reg <= wdo_sync_reg[2];
		end
	end
	assign pri_edge = (pri_sync_reg[1] == pri_sync_reg[2]) && pri_sync_reg[2]
		&& !pri_level_reg;
	assign wdo_edge = (wdo_sync_reg[1] == wdo_sync_reg[2]) && wdo_sync_reg[2]
		&& !wdo_level_reg;

	// Primary clock watchdog
	assign pri_fail_now = ctrl_reg.pri_fen && !pri_failed_reg && !wdo_failed_reg
		&& (pri_cnt_reg == 16'(OSCSF_PRI_FAIL_CYCLES - 1));
	always_ff @(posedge clk) begin
		if (rst) begin
			pri_cnt_reg <= 16'h0000;
		end else if (!ctrl_reg.pri_fen || pri_edge || pri_failed_reg || wdo_failed_reg
			|| ctrl_wr) begin
			pri_cnt_reg <= 16'h0000;
		end else begin
			pri_cnt_reg <= pri_cnt_reg + 16'h0001;
		end
	end

	// Watchdog oscillator supervisor
	assign wdo_fail_now = ctrl_reg.wdo_fen && !wdo_failed_reg
		&& (wdo_cnt_reg == 14'(OSCSF_WDO_FAIL_CYCLES - 1));
	always_ff @(posedge clk) begin
		if (rst) begin
			wdo_cnt_reg <= 14'h0000;
		end else if (!ctrl_reg.wdo_fen || wdo_edge || wdo_failed_reg || ctrl_wr) begin
			wdo_cnt_reg <= 14'h0000;
		end else begin
			wdo_cnt_reg <= wdo_cnt_reg + 14'h0001;
		end
	end

	// Primary failure flag, cleared by disabling its detector; detection wins
	always_ff @(posedge clk) begin
		if (rst) begin
			pri_failed_reg <= 1'b0;
		end else begin
			pri_failed_reg <= pri_fail_now || (pri_failed_reg && ctrl_reg.pri_fen);
		end
	end

	// Watchdog oscillator failure flag, same clearing rule
	always_ff @(posedge clk) begin
		if (rst) begin
			wdo_failed_reg <= 1'b0;
		end else begin
			wdo_failed_reg <= wdo_fail_now || (wdo_failed_reg && ctrl_reg.wdo_fen);
		end
	end

	// Nonmaskable event pulse
	always_ff @(posedge clk) begin
		if (rst) begin
			nmi_reg <= 1'b0;
		end else begin
			nmi_reg <= pri_fail_now || wdo_fail_now;
		end
	end

	// Active source; failover overrides software selection
	assign failover_now = pri_fail_now && ctrl_reg.wdo_en && (ctrl_reg.sel != OSCSF_SRC_WDO);
	always_ff @(posedge clk) begin
		if (rst) begin
			active_src_reg <= OSCSF_SRC_IPO_FAST;
		end else if (failover_now) begin
			active_src_reg <= OSCSF_SRC_WDO;
		end else if (ctrl_commit) begin
			active_src_reg <= ctrl_wdata.sel;
		end else if (!failover_reg) begin
			active_src_reg <= ctrl_reg.sel;
		end
	end

	// Failover persists until the next unlocked control write
	always_ff @(posedge clk) begin
		if (rst) begin
			failover_reg <= 1'b0;
		end else if (failover_now) begin
			failover_reg <= 1'b1;
		end else if (ctrl_commit) begin
			failover_reg <= 1'b0;
		end
	end

	// Hold request for glitch-free mux on every source change
	always_ff @(posedge clk) begin
		if (rst) begin
			hold_reg <= 1'b0;
		end else begin
			hold_reg <= (active_src_reg != clock_source_select);
		end
	end

	// Registered select to the clock mux
	always_ff @(posedge clk) begin
		if (rst) begin
			clock_source_select <= OSCSF_SRC_IPO_FAST;
		end else begin
			clock_source_select <= active_src_reg;
		end
	end

	// Hold hint, event pulse and oscillator enables
	assign clk_switch_hold = hold_reg;
	assign clock_fail_nmi = nmi_reg;
	assign internal_osc_enable = ctrl_reg.int_en;
	assign crystal_osc_enable = ctrl_reg.xtl_en;
	assign watchdog_osc_enable = ctrl_reg.wdo_en;

	// Status word for software
	always_comb begin
		status = '0;
		status.active_src = active_src_reg;
		status.failover = failover_reg;
		status.pri_failed = pri_failed_reg;
		status.wdo_failed = wdo_failed_reg;
		status.lock_state = lock_reg;
	end

	// Read data
	always_ff @(posedge clk) begin
		if (rst) begin
			hrdata_reg <= 32'h00000000;
		end else if (hready && hsel && (htrans == OSCSF_HTRANS_NONSEQ) && !hwrite) begin
			case (haddr[11:0])
				OSCSF_CTRL_OFFSET: begin
					hrdata_reg <= {24'h000000, ctrl_reg};
				end
				OSCSF_STATUS_OFFSET: begin
					hrdata_reg <= {24'h000000, status};
				end
				default: begin
					hrdata_reg <= 32'h00000000;
				end
			endcase
		end
	end
endmodule

// File: tb/oscsf_assertions.sv
// Concurrent checks on the ports of the oscillator select block.
// Assumes one clock, synchronous reset and a zero-wait bus slave.
module oscsf_assertions
	import oscsf_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [2:0] clock_source_select,
	input wire logic clk_switch_hold,
	input wire logic internal_osc_enable,
	input wire logic crystal_osc_enable,
	input wire logic watchdog_osc_enable,
	input wire logic clock_fail_nmi
);
	logic ap;
	logic wr;
	logic rd_q;
	logic [2:0] wr_h;
	logic [2:0] nmi_h;
	logic [13:0] quiet;
	assign ap = hsel && hready && htrans == OSCSF_HTRANS_NONSEQ;
	assign wr = ap && hwrite && haddr[11:0] == OSCSF_CTRL_OFFSET;
	always_ff @(posedge clk) begin
		if (rst) begin
			wr_h <= 3'h0;
			nmi_h <= 3'h0;
			rd_q <= 1'b0;
			quiet <= 14'h0;
		end else begin
			wr_h <= {wr_h[1:0], wr};
			nmi_h <= {nmi_h[1:0], clock_fail_nmi};
			rd_q <= ap && !hwrite;
			quiet <= wr ? 14'h0 : (quiet == 14'h3FFF ? quiet : quiet + 14'h1);
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_fail_pulse;
		clock_fail_nmi ##1 !clock_fail_nmi [*8];
	endsequence
	chk_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus answer not ready or not okay");
	chk_reset_vals: assert property (disable iff (1'b0) $fell(rst) |->
		clock_source_select == 3'h0 && !clock_fail_nmi &&
		{internal_osc_enable, crystal_osc_enable, watchdog_osc_enable} == 3'h5)
		else $error("wrong values at reset release");
	chk_nmi_pulse: assert property ($rose(clock_fail_nmi) |-> s_fail_pulse)
		else $error("failure event not a single pulse");
	chk_nmi_delay: assert property (clock_fail_nmi |-> quiet >= 14'h1F44)
		else $error("failure event too early");
	chk_enable_hold: assert property (wr_h == 3'h0 |->
		$stable({internal_osc_enable, crystal_osc_enable, watchdog_osc_enable}))
		else $error("enables changed without control write");
	chk_select_hold: assert property (wr_h == 3'h0 && nmi_h == 3'h0 && !clock_fail_nmi
		|-> $stable(clock_source_select))
		else $error("source changed without cause");
	chk_select_legal: assert property (clock_source_select <= 3'h4)
		else $error("reserved source code driven");
	chk_hold_marks: assert property (clk_switch_hold == $changed(clock_source_select))
		else $error("switch hold not matching source change");
	chk_rdata_hold: assert property (!rd_q |-> $stable(hrdata))
		else $error("read data changed without read");
endmodule
bind oscsf_top oscsf_assertions u_oscsf_assertions (.*);

// File: tb/test_oscillator_select_failover.sv
// Bench for the oscillator select block over its register bus.
// Assumes hready looped from hreadyout and bench-made oscillator levels.
module test_oscillator_select_failover
	import oscsf_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst = 1, hsel = 0, hwrite = 0, pclk = 0, wclk = 0, prun = 1, wrun = 1;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, q, hrdata;
	logic [1:0] htrans = 2'h0;
	logic hreadyout, hresp, hold, ien, xen, wen, nmi;
	logic [2:0] sel;
	int err_count = 0, num_checks = 0, cyc = 0, n;
	oscsf_top u_oscsf_top (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .primary_clk_in(pclk), .wdo_clk_in(wclk),
		.clock_source_select(sel), .clk_switch_hold(hold), .internal_osc_enable(ien),
		.crystal_osc_enable(xen), .watchdog_osc_enable(wen), .clock_fail_nmi(nmi));
	always #10 clk = ~clk;
	task automatic complete_run;
		$display("errors %0d checks %0d", err_count, num_checks);
		if (err_count == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	always @(posedge clk) begin
		if (prun && cyc[0]) pclk <= ~pclk;
		if (wrun && cyc[0]) wclk <= ~wclk;
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			err_count++;
			complete_run();
		end
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			err_count++;
			$display("Error t=%0t seen %h exp %h", $time, s, e);
		end
	endtask
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= OSCSF_HTRANS_NONSEQ;
		hwrite <= w;
		haddr <= {20'h0, a};
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		q = hrdata;
	endtask
	task automatic unl(input logic [7:0] d);
		bus(1, 0, 32'hE7);
		bus(1, 0, 32'h18);
		bus(1, 0, {24'h0, d});
		repeat (3) @(posedge clk);
	endtask
	task automatic wnmi;
		n = 0;
		while (nmi !== 1'b1 && n < 60000) begin
			@(posedge clk);
			n++;
		end
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		bus(0, 0, 0);
		chk(q, 32'hA0);
		chk({29'h0, ien, xen, wen}, 32'h5);
		bus(1, 0, 0);
		bus(1, 0, 32'h18);
		bus(1, 0, 32'h55);
		bus(0, 0, 0);
		chk(q, 32'hA0);
		bus(1, 0, 32'hE7);
		bus(0, 4, 0);
		chk({30'h0, q[1:0]}, 32'h1);
		bus(0, 8, 0);
		chk(q, 32'h0);
		bus(1, 0, 32'h18);
		bus(1, 0, 32'hB1);
		bus(0, 0, 0);
		chk(q, 32'hB1);
		bus(1, 0, 0);
		bus(0, 0, 0);
		chk(q, 32'hB1);
		bus(1, 0, 32'hE7);
		unl(8'hA5);
		bus(0, 0, 0);
		chk(q, 32'hA1);
		unl(8'hE0);
		repeat (20) @(posedge clk);
		chk({29'h0, ien, xen, wen}, 32'h7);
		for (int i = 0; i < 5; i++) begin
			unl(8'hE0 | 8'(i));
			chk({29'h0, sel}, i);
		end
		unl(8'hB0);
		prun <= 1'b0;
		wnmi();
		chk(32'(nmi === 1'b1 && n > 33333 && n < 75000), 32'h1);
		repeat (3) @(posedge clk);
		chk({29'h0, sel}, 32'h3);
		prun <= 1'b1;
		unl(8'hA8);
		chk({29'h0, sel}, 32'h0);
		wrun <= 1'b0;
		wnmi();
		chk(32'(nmi === 1'b1 && n > 7980 && n < 8020), 32'h1);
		repeat (3) @(posedge clk);
		chk({29'h0, sel}, 32'h0);
		complete_run();
	end
endmodule
